// ===== hdl/scr_pkg.sv
// Contract
// - reset-cause write kicks watchdog, keeps contents
// - power-on sets bits 7 and 1 only
// - other resets latch active sources, bits 7,1 zero; low-supply reset sets bit 1 only, keeps bit 7; debug reset clears all unless low-supply reset pending
// - bit 6 marks external reset pin
// - bit 5 marks watchdog; disabled watchdog never resets
// - bit 4 marks bad opcode, stop, debug instruction
// - bit 3 marks unimplemented address access
// - bit 1 marks enabled low-supply reset or power-on
// - options accept first write only, always readable
// - options bit 7 watchdog on, bit 6 long
// - options bit 5 halt enable, else illegal
// - options bit 4 moves two-wire pins
// - options bits 3,2 move timer channel pins
// - debug pin enable reset value depends on mode
// - debug pin enable only cleared by software
// - options bit 0 reset pin, cleared by power-on
// - identification pair read-only, revision plus part
// - periodic flag set on timeout, ack clears
// - control bit 5 picks internal or external clock
// - control bit 4 enables periodic interrupt
// - select zero stops counter, others internal periods
// - external clock periods 256 to 32768 edges
package scr_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int           ADR_W    = 5;
    localparam logic [4:0]   ADR_CAUSE = 5'h00;
    localparam logic [4:0]   ADR_OPTS  = 5'h04;
    localparam logic [4:0]   ADR_IDH   = 5'h08;
    localparam logic [4:0]   ADR_IDL   = 5'h0C;
    localparam logic [4:0]   ADR_RTC   = 5'h10;
    localparam logic [4:0]   ADR_SPM   = 5'h14;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CAUSE_POR  = 7;
    localparam int CAUSE_PIN  = 6;
    localparam int CAUSE_WDOG = 5;
    localparam int CAUSE_OPC  = 4;
    localparam int CAUSE_ADR  = 3;
    localparam int CAUSE_LVR  = 1;
    localparam int OPT_WDOG   = 7;
    localparam int OPT_LONG   = 6;
    localparam int OPT_HALT   = 5;
    localparam int OPT_TWI    = 4;
    localparam int OPT_CH1    = 3;
    localparam int OPT_CH0    = 2;
    localparam int OPT_DBG    = 1;
    localparam int OPT_RSTPIN = 0;
    localparam int RTC_FLAG   = 7;
    localparam int RTC_ACK    = 6;
    localparam int RTC_CLKS   = 5;
    localparam int RTC_IEN    = 4;
    localparam int SPM_FLAG   = 7;
    localparam int SPM_ACK    = 6;
    localparam int SPM_IEN    = 5;
    localparam int SPM_RSTEN  = 4;
    localparam int SPM_DET    = 2;

    // ------------------------------------------------------------
    // reset values and write masks
    // ------------------------------------------------------------
    localparam logic [7:0] CAUSE_POR_VAL = 8'h82;
    localparam logic [7:0] OPTS_RST      = 8'hC2;
    localparam logic [7:0] SPM_RST       = 8'h1C;
    localparam logic [7:0] RTC_WMASK     = 8'h37;
    localparam logic [7:0] SPM_WMASK     = 8'h29;
    localparam logic [7:0] SPM_ONCE      = 8'h14;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int         CLK_HZ      = 10_000_000;
    localparam int         TICK_HZ     = 1_000;
    localparam int         KHZ_DIV_DEF = CLK_HZ / TICK_HZ;
    localparam logic [8:0] WDOG_SHORT  = 9'h020;
    localparam logic [8:0] WDOG_LONG   = 9'h100;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic por;
        logic low_supply_trip;
        logic low_supply_detect;
        logic bad_opcode;
        logic bad_access;
        logic stop_instr;
        logic debug_instr;
        logic debug_enable;
        logic debug_reset;
        logic debug_active;
        logic stop_active;
    } scr_src_t;

    // terminal count of the periodic counter, in ticks or edges
    function automatic logic [15:0] rtc_limit(input logic       ext,
                                              input logic [2:0] sel);
        logic [15:0] v;
        v = 16'h0000;
        case (sel)
            3'h1:    v = ext ? 16'h0100 : 16'h0008;
            3'h2:    v = ext ? 16'h0400 : 16'h0020;
            3'h3:    v = ext ? 16'h0800 : 16'h0040;
            3'h4:    v = ext ? 16'h1000 : 16'h0080;
            3'h5:    v = ext ? 16'h2000 : 16'h0100;
            3'h6:    v = ext ? 16'h4000 : 16'h0200;
            3'h7:    v = ext ? 16'h8000 : 16'h0400;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

endpackage

// ===== hdl/scr_bank.sv
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
module scr_bank #(
    parameter int         KHZ_DIV = scr_pkg::KHZ_DIV_DEF,
    // arbitrary neutral identification values
    parameter logic [3:0] ID_REV  = 4'h1,
    parameter logic [11:0] PART_ID = 12'h5A1
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     cyc_i,
    input  wire logic                     stb_i,
    input  wire logic                     we_i,
    input  wire logic [3:0]               sel_i,
    input  wire logic [scr_pkg::ADR_W-1:0] adr_i,
    input  wire logic [31:0]              dat_i,
    output logic      [31:0]              dat_o,
    output logic                          ack_o,
    input  wire scr_pkg::scr_src_t        src_i,
    input  wire logic                     reset_pin_n_i,
    input  wire logic                     ext_clk_i,
    input  wire logic                     mode_select_line_i,
    input  wire logic                     flash_unsecured_i,
    output logic                          reset_req_o,
    output logic                          periodic_irq_o,
    output logic                          low_supply_irq_o,
    output logic                          watchdog_enable_o,
    output logic                          halt_mode_enable_o,
    output logic                          two_wire_pin_select_o,
    output logic                          timer_ch_one_pin_select_o,
    output logic                          timer_ch_zero_pin_select_o,
    output logic                          debug_pin_enable_o,
    output logic                          reset_pin_enable_o,
    output logic                          reference_buffer_enable_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        ack;
        logic [7:0]  rdata;
        logic [7:0]  cause;
        logic        p_pin;
        logic        p_wdog;
        logic        p_opc;
        logic        p_adr;
        logic        p_lvr;
        logic        in_rst;
        logic [7:0]  opts;
        logic        opts_wr;
        logic [7:0]  spm;
        logic        spm_wr;
        logic [7:0]  rtc;
        logic        rflag;
        logic [15:0] rcnt;
        logic [15:0] div;
        logic [8:0]  wcnt;
        logic        reset_req;
        logic        irq;
        logic        lvirq;
        logic [2:0]  pin_s;
        logic        pin_lvl;
        logic [2:0]  ext_s;
        logic        ext_lvl;
    } scr_state_t;

    scr_state_t  s;
    scr_state_t  next_s;
    logic        req;
    logic        wr;
    logic        wr_cause;
    logic        wr_opts;
    logic        wr_rtc;
    logic        wr_spm;
    logic        tick;
    logic        ext_rise;
    logic        rtc_step;
    logic        rtc_hit;
    logic        wdog_hit;
    logic [8:0]  wlim;
    logic [15:0] rlim;
    logic [7:0]  wd;

    assign dat_o                      = {24'h000000, s.rdata};
    assign ack_o                      = s.ack;
    assign reset_req_o                = s.reset_req;
    assign periodic_irq_o             = s.irq;
    assign low_supply_irq_o           = s.lvirq;
    assign watchdog_enable_o          = s.opts[scr_pkg::OPT_WDOG];
    assign halt_mode_enable_o         = s.opts[scr_pkg::OPT_HALT];
    assign two_wire_pin_select_o      = s.opts[scr_pkg::OPT_TWI];
    assign timer_ch_one_pin_select_o  = s.opts[scr_pkg::OPT_CH1];
    assign timer_ch_zero_pin_select_o = s.opts[scr_pkg::OPT_CH0];
    assign debug_pin_enable_o         = s.opts[scr_pkg::OPT_DBG];
    assign reset_pin_enable_o         = s.opts[scr_pkg::OPT_RSTPIN];
    assign reference_buffer_enable_o  = s.spm[0];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s   = s;
        wd       = dat_i[7:0];
        req      = cyc_i & stb_i;
        // writes land on the edge at which the master sees ack
        wr       = req & s.ack & we_i & sel_i[0];
        wr_cause = wr & (adr_i == scr_pkg::ADR_CAUSE);
        wr_opts  = wr & (adr_i == scr_pkg::ADR_OPTS);
        wr_rtc   = wr & (adr_i == scr_pkg::ADR_RTC);
        wr_spm   = wr & (adr_i == scr_pkg::ADR_SPM);

        next_s.ack = req & ~s.ack;
        if (req & ~s.ack) begin
            case (adr_i)
                scr_pkg::ADR_CAUSE: next_s.rdata = s.cause;
                scr_pkg::ADR_OPTS:  next_s.rdata = s.opts;
                scr_pkg::ADR_IDH:   next_s.rdata = {ID_REV,
                                                    PART_ID[11:8]};
                scr_pkg::ADR_IDL:   next_s.rdata = PART_ID[7:0];
                // ack bit is write-only and always reads zero
                scr_pkg::ADR_RTC:   next_s.rdata = {s.rflag,
                                                    s.rtc[6:0]};
                scr_pkg::ADR_SPM:   next_s.rdata = s.spm;
                default:            next_s.rdata = 8'h00;
            endcase
        end

        // pins: three stages, level accepted once the last two agree
        next_s.pin_s = {s.pin_s[1:0], reset_pin_n_i};
        next_s.ext_s = {s.ext_s[1:0], ext_clk_i};
        if (s.pin_s[1] == s.pin_s[2]) begin
            next_s.pin_lvl = s.pin_s[2];
        end
        if (s.ext_s[1] == s.ext_s[2]) begin
            next_s.ext_lvl = s.ext_s[2];
        end
        ext_rise = next_s.ext_lvl & ~s.ext_lvl;

        // 1 kHz time base from the bus clock
        tick = (s.div == 16'(KHZ_DIV - 1));
        next_s.div = tick ? 16'h0000 : s.div + 16'h0001;

        // watchdog
        wlim     = s.opts[scr_pkg::OPT_LONG] ? scr_pkg::WDOG_LONG
                                             : scr_pkg::WDOG_SHORT;
        wdog_hit = 1'b0;
        if (wr_cause | (wr_opts & ~s.opts_wr) | src_i.stop_active) begin
            next_s.wcnt = 9'h000;
        end else if (tick & s.opts[scr_pkg::OPT_WDOG]
                     & ~src_i.debug_active) begin
            if (s.wcnt == wlim - 9'h001) begin
                next_s.wcnt = 9'h000;
                wdog_hit    = 1'b1;
            end else begin
                next_s.wcnt = s.wcnt + 9'h001;
            end
        end

        // reset sources held until the reset itself arrives;
        // the copy frozen through reset is dropped on the first
        // edge after it, else the request would come straight back
        next_s.in_rst = 1'b0;
        next_s.p_wdog = (s.p_wdog & ~s.in_rst) | wdog_hit;
        next_s.p_opc  = (s.p_opc & ~s.in_rst) | src_i.bad_opcode
                      | (src_i.stop_instr & ~s.opts[scr_pkg::OPT_HALT])
                      | (src_i.debug_instr
                         & ~src_i.debug_enable);
        next_s.p_adr  = (s.p_adr & ~s.in_rst) | src_i.bad_access;
        next_s.p_lvr  = (s.p_lvr & ~s.in_rst) | (src_i.low_supply_trip
                      & s.spm[scr_pkg::SPM_DET]
                      & s.spm[scr_pkg::SPM_RSTEN]);
        next_s.p_pin  = (s.p_pin & ~s.in_rst) | (~s.pin_lvl
                      & s.opts[scr_pkg::OPT_RSTPIN]);
        next_s.reset_req = next_s.p_wdog | next_s.p_opc | next_s.p_adr
                         | next_s.p_lvr | next_s.p_pin;

        // options, honoured once per reset
        if (wr_opts & ~s.opts_wr) begin
            next_s.opts = {wd[7:2], wd[1] & s.opts[scr_pkg::OPT_DBG],
                           wd[0]};
            next_s.opts_wr = 1'b1;
        end

        // periodic timer
        rlim     = scr_pkg::rtc_limit(s.rtc[scr_pkg::RTC_CLKS], s.rtc[2:0]);
        rtc_step = s.rtc[scr_pkg::RTC_CLKS] ? ext_rise : tick;
        rtc_hit  = 1'b0;
        if (s.rtc[2:0] == 3'h0) begin
            next_s.rcnt = 16'h0000;
        end else if (rtc_step) begin
            if (s.rcnt >= rlim - 16'h0001) begin
                next_s.rcnt = 16'h0000;
                rtc_hit     = 1'b1;
            end else begin
                next_s.rcnt = s.rcnt + 16'h0001;
            end
        end
        if (wr_rtc) begin
            next_s.rtc = wd & scr_pkg::RTC_WMASK;
            if (wd[scr_pkg::RTC_ACK]) begin
                next_s.rflag = 1'b0;
            end
        end
        // a timeout in the ack cycle still sets the flag
        if (rtc_hit) begin
            next_s.rflag = 1'b1;
        end
        next_s.irq = next_s.rflag
                   & next_s.rtc[scr_pkg::RTC_IEN];

        // supply monitor: two fields are write-once
        if (wr_spm) begin
            next_s.spm = (s.spm & ~scr_pkg::SPM_WMASK)
                       | (wd & scr_pkg::SPM_WMASK);
            if (~s.spm_wr) begin
                next_s.spm = (next_s.spm & ~scr_pkg::SPM_ONCE)
                           | (wd & scr_pkg::SPM_ONCE);
                next_s.spm_wr = 1'b1;
            end
            if (wd[scr_pkg::SPM_ACK]) begin
                next_s.spm[scr_pkg::SPM_FLAG] = 1'b0;
            end
        end
        if (src_i.low_supply_detect & s.spm[scr_pkg::SPM_DET]) begin
            next_s.spm[scr_pkg::SPM_FLAG] = 1'b1;
        end
        next_s.lvirq = next_s.spm[scr_pkg::SPM_FLAG]
                     & next_s.spm[scr_pkg::SPM_IEN];

        // ------------------------------------------------------------
        // reset: cause capture and reset values
        // ------------------------------------------------------------
        if (rst_i) begin
            if (src_i.por) begin
                next_s.cause = scr_pkg::CAUSE_POR_VAL;
            end else if (s.p_lvr) begin
                next_s.cause = {s.cause[scr_pkg::CAUSE_POR], 7'h02};
            end else if (src_i.debug_reset) begin
                next_s.cause = 8'h00;
            end else begin
                next_s.cause = {1'b0, s.p_pin, s.p_wdog, s.p_opc,
                                s.p_adr, 3'h0};
            end
            next_s.opts = {scr_pkg::OPTS_RST[7:2],
                           src_i.por | ~mode_select_line_i
                           | flash_unsecured_i,
                           s.opts[0] & ~src_i.por};
            next_s.opts_wr   = 1'b0;
            next_s.spm       = scr_pkg::SPM_RST;
            next_s.spm_wr    = 1'b0;
            next_s.rtc       = 8'h00;
            next_s.rflag     = 1'b0;
            next_s.rcnt      = 16'h0000;
            next_s.div       = 16'h0000;
            next_s.wcnt      = 9'h000;
            // sources stay as at reset entry, so every reset edge
            // loads the same cause, the last one included
            next_s.in_rst    = 1'b1;
            next_s.p_pin     = s.p_pin;
            next_s.p_wdog    = s.p_wdog;
            next_s.p_opc     = s.p_opc;
            next_s.p_adr     = s.p_adr;
            next_s.p_lvr     = s.p_lvr;
            next_s.reset_req = 1'b0;
            next_s.irq       = 1'b0;
            next_s.lvirq     = 1'b0;
            next_s.ack       = 1'b0;
            next_s.rdata     = 8'h00;
            next_s.pin_s     = 3'h7;
            next_s.pin_lvl   = 1'b1;
            next_s.ext_s     = 3'h0;
            next_s.ext_lvl   = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        s <= next_s;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_wdog_kick: assert property (wr_cause |=> s.wcnt == 9'h000
        && s.cause == $past(s.cause))
        else $error("cause write did not kick watchdog");

    a_por_cause: assert property ($past(rst_i) && $past(src_i.por)
        |-> s.cause == 8'h82 && s.opts[0] == 1'b0 && s.opts[1])
        else $error("power-on cause or options wrong");

    a_other_cause: assert property ($past(rst_i) && !$past(src_i.por)
        && !$past(s.p_lvr) |-> !s.cause[7] && !s.cause[1]
        && s.cause[6] == ($past(s.p_pin) && !$past(src_i.debug_reset)))
        else $error("non power-on cause wrong");

    a_wdog_off: assert property (!s.opts[7] && !s.p_wdog
        |=> !s.p_wdog)
        else $error("disabled watchdog raised reset");

    a_stop_bad: assert property (src_i.stop_instr && !s.opts[5]
        |=> s.p_opc && s.reset_req)
        else $error("stop without halt enable not trapped");

    a_opts_once: assert property (wr_opts && s.opts_wr
        |=> $stable(s.opts))
        else $error("second options write took effect");

    a_dbg_noset: assert property (!s.opts[1] |=> !s.opts[1])
        else $error("debug pin enable set by software");

    a_rtc_ack: assert property (wr_rtc && dat_i[6] && !rtc_hit
        |=> !s.rflag && !s.irq)
        else $error("periodic ack did not clear flag");

    a_rtc_off: assert property (s.rtc[2:0] == 3'h0
        |=> s.rcnt == 16'h0000 && !rtc_hit)
        else $error("periodic counter runs while off");

    a_irq_gate: assert property (s.irq == (s.rflag && s.rtc[4]))
        else $error("periodic irq not flag and enable");

    a_lvr_cause: assert property ($past(rst_i) && !$past(src_i.por)
        && $past(s.p_lvr) |-> s.cause[1] && s.cause[6:2] == 5'h00)
        else $error("low-supply reset cause wrong");

    a_wdog_fire: assert property (wdog_hit |=> s.p_wdog && s.reset_req)
        else $error("watchdog timeout did not request reset");

    a_opts_lock: assert property (wr_opts && !s.opts_wr |=> s.opts_wr)
        else $error("first options write did not lock");

    a_rtc_set: assert property (rtc_hit |=> s.rflag)
        else $error("periodic timeout did not set flag");

    // one answer per request, then a gap before the next
    a_ack_pulse: assert property (s.ack |=> !s.ack)
        else $error("bus ack held longer than one cycle");

endmodule

// ===== tb/tb_scr_bank.sv
`timescale 1ns/100ps
module tb_scr_bank;
    // ------------------------------------------------------------
    // setup
    // ------------------------------------------------------------
    // short prescaler keeps the periodic counter tests quick
    localparam int DIV   = 4;
    localparam int LIMIT = 40000;
    logic              clk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic              cyc   = 1'b0;
    logic              stb   = 1'b0;
    logic              we    = 1'b0;
    logic [3:0]        sel   = 4'h0;
    logic [4:0]        adr   = 5'h00;
    logic [31:0]       dat   = 32'h0;
    scr_pkg::scr_src_t src   = '0;
    logic              pin_n = 1'b1;
    logic              ms    = 1'b1;
    logic              fu    = 1'b0;
    logic [3:0]        ediv  = 4'h0;
    logic [31:0]       dout;
    logic              ack, req, pirq, wd, ht, tw, c1, c0, dbg, rp, lirq, bge;
    int                err_count = 0;
    int                n_tests   = 0;
    int                cyc_n     = 0;
    int                lims [7]  = '{8, 32, 64, 128, 256, 512, 1024};
    logic [7:0]        cexp [6]  = '{8'h40, 8'h10, 8'h08, 8'h10, 8'h10, 8'h02};

    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) ediv <= ediv + 4'h1;

    // identification values are arbitrary
    scr_bank #(.KHZ_DIV(DIV), .ID_REV(4'h3), .PART_ID(12'h2C7)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .sel_i(sel), .adr_i(adr), .dat_i(dat), .dat_o(dout), .ack_o(ack),
        .src_i(src), .reset_pin_n_i(pin_n), .ext_clk_i(ediv[1]),
        .mode_select_line_i(ms), .flash_unsecured_i(fu),
        .reset_req_o(req), .periodic_irq_o(pirq), .low_supply_irq_o(lirq),
        .watchdog_enable_o(wd), .halt_mode_enable_o(ht),
        .two_wire_pin_select_o(tw), .timer_ch_one_pin_select_o(c1),
        .timer_ch_zero_pin_select_o(c0), .debug_pin_enable_o(dbg),
        .reset_pin_enable_o(rp), .reference_buffer_enable_o(bge));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == LIMIT) begin
            err_count++;
            test_done();
        end
    end

    task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_bit(input logic g, input logic e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wb(input logic w, input logic [4:0] a,
                      input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= {24'h0, d};
        sel <= 4'hF;
        // only the bench timeout ends this wait
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        chk_bit(ack, 1'b1);
        q = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        logic [31:0] q;
        wb(1'b0, a, 8'h00, q);
        chk_val(q, {24'h0, e});
    endtask

    task automatic do_rst(input logic p);
        @(posedge clk_i);
        src.por <= p;
        rst_i   <= 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        src   <= '0;
    endtask

    // flag stays set until acked, so callers ack first; this returns once the irq is high or 10000 cycles pass
    task automatic wait_irq(output int t);
        int n;
        n = 0;
        repeat (2) @(posedge clk_i);
        while (pirq !== 1'b1 && n < 10000) begin
            @(posedge clk_i);
            n++;
        end
        t = cyc_n;
    endtask

    task automatic per(input logic [7:0] ctl, input int exp_c);
        int t1;
        int t2;
        wr(scr_pkg::ADR_RTC, ctl);
        wait_irq(t1);
        rd(scr_pkg::ADR_RTC, (ctl & 8'hBF) | 8'h80);
        // a timeout in the ack cycle of the first write would skew t1
        wr(scr_pkg::ADR_RTC, ctl);
        wait_irq(t1);
        wr(scr_pkg::ADR_RTC, ctl);
        wait_irq(t2);
        chk_val(t2 - t1, exp_c);
        chk_bit(pirq, 1'b1);
    endtask

    function automatic logic [7:0] pins();
        return {wd, 1'b0, ht, tw, c1, c0, dbg, rp};
    endfunction

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        src.por = 1'b1;
        do_rst(1'b1);
        rd(scr_pkg::ADR_CAUSE, 8'h82);
        rd(scr_pkg::ADR_OPTS, 8'hC2);
        chk_val(pins(), 8'h82);
        wr(scr_pkg::ADR_IDH, 8'hFF);
        wr(scr_pkg::ADR_IDL, 8'h00);
        rd(scr_pkg::ADR_IDH, 8'h32);
        rd(scr_pkg::ADR_IDL, 8'hC7);
        rd(scr_pkg::ADR_RTC, 8'h00);
        rd(scr_pkg::ADR_SPM, 8'h1C);
        rd(5'h18, 8'h00);
        $display("test power_on done");

        wr(scr_pkg::ADR_OPTS, 8'h3D);
        wr(scr_pkg::ADR_OPTS, 8'hFF);
        rd(scr_pkg::ADR_OPTS, 8'h3D);
        chk_val(pins(), 8'h3D);
        repeat (300) @(posedge clk_i);
        chk_bit(req, 1'b0);
        $display("test options_once done");

        fu <= 1'b0;
        do_rst(1'b0);
        rd(scr_pkg::ADR_OPTS, 8'hC1);
        rd(scr_pkg::ADR_CAUSE, 8'h00);
        wr(scr_pkg::ADR_OPTS, 8'h03);
        rd(scr_pkg::ADR_OPTS, 8'h01);
        ms <= 1'b0;
        do_rst(1'b0);
        rd(scr_pkg::ADR_OPTS, 8'hC3);
        ms <= 1'b1;
        fu <= 1'b1;
        $display("test debug_pin done");

        for (int k = 0; k < 6; k++) begin
            do_rst(1'b0);
            if (k == 5)
                wr(scr_pkg::ADR_SPM, 8'h14);
            @(posedge clk_i);
            case (k)
                0: pin_n <= 1'b0;
                1: src.bad_opcode <= 1'b1;
                2: src.bad_access <= 1'b1;
                3: src.stop_instr <= 1'b1;
                4: src.debug_instr <= 1'b1;
                default: src.low_supply_trip <= 1'b1;
            endcase
            repeat (10) @(posedge clk_i);
            pin_n <= 1'b1;
            chk_bit(req, 1'b1);
            do_rst(1'b0);
            rd(scr_pkg::ADR_CAUSE, cexp[k]);
        end
        $display("test reset_sources done");

        wr(scr_pkg::ADR_OPTS, 8'h81);
        rd(scr_pkg::ADR_OPTS, 8'h81);
        repeat (5) begin
            repeat (40) @(posedge clk_i);
            wr(scr_pkg::ADR_CAUSE, 8'hFF);
        end
        chk_bit(req, 1'b0);
        rd(scr_pkg::ADR_CAUSE, 8'h02);
        for (int n = 0; n < 200 && req !== 1'b1; n++)
            @(posedge clk_i);
        chk_bit(req, 1'b1);
        do_rst(1'b0);
        rd(scr_pkg::ADR_CAUSE, 8'h20);
        $display("test watchdog done");

        wr(scr_pkg::ADR_OPTS, 8'h01);
        wr(scr_pkg::ADR_SPM, 8'h35);
        rd(scr_pkg::ADR_SPM, 8'h35);
        chk_bit(bge, 1'b1);
        @(posedge clk_i);
        src.low_supply_detect <= 1'b1;
        @(posedge clk_i);
        src.low_supply_detect <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk_bit(lirq, 1'b1);
        wr(scr_pkg::ADR_SPM, 8'h75);
        @(posedge clk_i);
        chk_bit(lirq, 1'b0);
        rd(scr_pkg::ADR_SPM, 8'h35);
        wr(scr_pkg::ADR_RTC, 8'h01);
        repeat (60) @(posedge clk_i);
        chk_bit(pirq, 1'b0);
        rd(scr_pkg::ADR_RTC, 8'h81);
        for (int s = 1; s < 8; s++)
            per(8'h50 | 8'(s), lims[s-1] * DIV);
        wr(scr_pkg::ADR_RTC, 8'h50);
        repeat (100) @(posedge clk_i);
        chk_bit(pirq, 1'b0);
        rd(scr_pkg::ADR_RTC, 8'h10);
        per(8'h71, 256 * 4);
        $display("test periodic done");
        test_done();
    end
endmodule
